// ===== hw/rtc_value_pkg.sv
// Constants shared by the time and alarm value window logic
package rtc_value_pkg;

  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 16;

  // Register addresses on the plain register port
  localparam logic [3:0]  CTRL_ADDR       = 4'h0;
  localparam logic [3:0]  ALARM_CFG_ADDR  = 4'h1;
  localparam logic [3:0]  TIME_WIN_ADDR   = 4'h2;
  localparam logic [3:0]  TIME_UPPER_ADDR = 4'h3;
  localparam logic [3:0]  ALARM_WIN_ADDR  = 4'h4;
  localparam logic [3:0]  ALARM_UPPER_ADDR = 4'h5;

  // Control and alarm configuration field positions
  localparam int          WREN_BIT        = 13;
  localparam int          PTR_LSB         = 8;
  localparam int          PTR_W           = 2;

  // Digit field positions inside the 16-bit windows
  localparam int          WEEKDAY_DIGIT_LSB        = 8;
  localparam int          HR_TENS_LSB     = 4;
  localparam int          HR_ONES_LSB     = 0;
  localparam int          MIN_TENS_LSB    = 12;
  localparam int          MIN_ONES_LSB    = 8;
  localparam int          SEC_TENS_LSB    = 4;
  localparam int          SEC_ONES_LSB    = 0;
  localparam int          MON_TENS_LSB    = 12;
  localparam int          MON_ONES_LSB    = 8;
  localparam int          DAY_TENS_LSB    = 4;
  localparam int          DAY_ONES_LSB    = 0;

  // Digit limits for the BCD counters
  localparam logic [3:0]  ONES_LAST       = 4'h9;
  localparam logic [2:0]  MS_TENS_LAST    = 3'h5;
  localparam logic [1:0]  HR_TENS_LAST    = 2'h2;
  localparam logic [3:0]  HR_ONES_LAST    = 4'h3;
  localparam logic [2:0]  WEEKDAY_DIGIT_LAST       = 3'h6;

  // Window pointer codes
  typedef enum logic [1:0] {
    PTR_MIN_SEC   = 2'h0,
    PTR_WKDY_HR   = 2'h1,
    PTR_MONTH_DAY = 2'h2,
    PTR_YEAR      = 2'h3
  } ptr_e;

endpackage : rtc_value_pkg

// ===== hw/bcd_pair_inc.sv
// Two-digit BCD increment with a programmable wrap point
`timescale 1ns/1ns
module bcd_pair_inc #(
  parameter int TENS_W = 3
) (
  input  wire logic [TENS_W-1:0] tens,
  input  wire logic [3:0]        ones,
  input  wire logic [TENS_W-1:0] last_tens,
  input  wire logic [3:0]        last_ones,
  input  wire logic [3:0]        ones_last,
  output logic      [TENS_W-1:0] next_tens,
  output logic      [3:0]        next_ones,
  output logic                   wrap
);

  if (TENS_W < 1 || TENS_W > 4) begin : g_bad_tens_width
    $error("bcd_pair_inc: TENS_W must be 1 to 4");
  end

  always_comb begin
    wrap      = (tens == last_tens) && (ones == last_ones);
    next_tens = tens;
    next_ones = ones + 4'h1;
    if (wrap) begin
      next_tens = '0;
      next_ones = 4'h0;
    end else if (ones == ones_last) begin
      next_tens = tens + TENS_W'(1);
      next_ones = 4'h0;
    end
  end

endmodule : bcd_pair_inc

// ===== hw/rtc_value_windows.sv
// Time-of-day and alarm value windows with pointer access and BCD timekeeping
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
// Operation
// - Time pointer 01 shows weekday 10-8, hours tens 5-4, hours ones 3-0.
// - Time pointer 00 shows minutes 14-12/11-8 and seconds 6-4/3-0.
// - Alarm pointer 10 shows month tens 12, ones 11-8, day 5-4/3-0.
// - Alarm pointer 01 shows weekday 10-8, hours tens 5-4, ones 3-0.
// - Alarm pointer 00 shows minutes 14-12/11-8, seconds 6-4/3-0.
// - Weekday/hours and alarm date/weekday writes need write enable set.
// - Unimplemented window bits read zero and ignore writes.
// - Digit fields have no reset value; software initialises them.
// - Time pointer decrements on each upper window access, stopping at 00.
// - Alarm pointer decrements on each upper window access, stopping at 00.
// - Time value registers locked against writes while write enable is 0.
module rtc_value_windows
  import rtc_value_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic              second_tick,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   timekeeping_write_enable,
  output logic      [DATA_W-1:0] time_weekday_hours,
  output logic      [DATA_W-1:0] time_minutes_seconds,
  output logic      [DATA_W-1:0] alarm_month_day,
  output logic      [DATA_W-1:0] alarm_weekday_hours,
  output logic      [DATA_W-1:0] alarm_minutes_seconds
);

  typedef struct packed {
    logic              wren;
    ptr_e              time_ptr;
    ptr_e              alarm_ptr;
    logic [2:0]        t_weekday_digit;
    logic [1:0]        t_hours_tens_digit;
    logic [3:0]        t_hours_ones_digit;
    logic [2:0]        t_minutes_tens_digit;
    logic [3:0]        t_minutes_ones_digit;
    logic [2:0]        t_seconds_tens_digit;
    logic [3:0]        t_seconds_ones_digit;
    logic              a_month_tens_digit;
    logic [3:0]        a_month_ones_digit;
    logic [1:0]        a_day_tens_digit;
    logic [3:0]        a_day_ones_digit;
    logic [2:0]        a_weekday_digit;
    logic [1:0]        a_hours_tens_digit;
    logic [3:0]        a_hours_ones_digit;
    logic [2:0]        a_minutes_tens_digit;
    logic [3:0]        a_minutes_ones_digit;
    logic [2:0]        a_seconds_tens_digit;
    logic [3:0]        a_seconds_ones_digit;
    logic [DATA_W-1:0] rd_data;
  } state_s;

  state_s s;
  state_s next_s;

  logic [2:0] sec_tens_inc;
  logic [3:0] sec_ones_inc;
  logic       sec_wrap;
  logic [2:0] min_tens_inc;
  logic [3:0] min_ones_inc;
  logic       min_wrap;
  logic [1:0] hr_tens_inc;
  logic [3:0] hr_ones_inc;
  logic       hr_wrap;

  // Packs a weekday and hours group into its window layout
  function automatic logic [DATA_W-1:0] view_wkdy_hr(
    input logic [2:0] weekday_digit,
    input logic [1:0] hr_tens,
    input logic [3:0] hr_ones
  );
    view_wkdy_hr = (DATA_W'(weekday_digit) << WEEKDAY_DIGIT_LSB)
                 | (DATA_W'(hr_tens) << HR_TENS_LSB)
                 | (DATA_W'(hr_ones) << HR_ONES_LSB);
  endfunction : view_wkdy_hr

  // Packs a minutes and seconds group into its window layout
  function automatic logic [DATA_W-1:0] view_min_sec(
    input logic [2:0] min_tens,
    input logic [3:0] min_ones,
    input logic [2:0] sec_tens,
    input logic [3:0] sec_ones
  );
    view_min_sec = (DATA_W'(min_tens) << MIN_TENS_LSB)
                 | (DATA_W'(min_ones) << MIN_ONES_LSB)
                 | (DATA_W'(sec_tens) << SEC_TENS_LSB)
                 | (DATA_W'(sec_ones) << SEC_ONES_LSB);
  endfunction : view_min_sec

  // Packs a month and day group into its window layout
  function automatic logic [DATA_W-1:0] view_month_day(
    input logic       mon_tens,
    input logic [3:0] mon_ones,
    input logic [1:0] day_tens,
    input logic [3:0] day_ones
  );
    view_month_day = (DATA_W'(mon_tens) << MON_TENS_LSB)
                   | (DATA_W'(mon_ones) << MON_ONES_LSB)
                   | (DATA_W'(day_tens) << DAY_TENS_LSB)
                   | (DATA_W'(day_ones) << DAY_ONES_LSB);
  endfunction : view_month_day

  // Pointer step after an upper window access, holding at zero
  function automatic ptr_e ptr_step(input ptr_e ptr);
    ptr_step = (ptr == PTR_MIN_SEC) ? PTR_MIN_SEC : ptr_e'(ptr - 2'h1);
  endfunction : ptr_step

  // Seconds and minutes wrap after 59, hours after 23
  bcd_pair_inc #(
    .TENS_W    (3)
  ) u_sec_inc (
    .tens      (s.t_seconds_tens_digit),
    .ones      (s.t_seconds_ones_digit),
    .last_tens (MS_TENS_LAST),
    .last_ones (ONES_LAST),
    .ones_last (ONES_LAST),
    .next_tens (sec_tens_inc),
    .next_ones (sec_ones_inc),
    .wrap      (sec_wrap)
  );

  bcd_pair_inc #(
    .TENS_W    (3)
  ) u_min_inc (
    .tens      (s.t_minutes_tens_digit),
    .ones      (s.t_minutes_ones_digit),
    .last_tens (MS_TENS_LAST),
    .last_ones (ONES_LAST),
    .ones_last (ONES_LAST),
    .next_tens (min_tens_inc),
    .next_ones (min_ones_inc),
    .wrap      (min_wrap)
  );

  bcd_pair_inc #(
    .TENS_W    (2)
  ) u_hr_inc (
    .tens      (s.t_hours_tens_digit),
    .ones      (s.t_hours_ones_digit),
    .last_tens (HR_TENS_LAST),
    .last_ones (HR_ONES_LAST),
    .ones_last (ONES_LAST),
    .next_tens (hr_tens_inc),
    .next_ones (hr_ones_inc),
    .wrap      (hr_wrap)
  );

  // Window accesses that may walk a pointer
  logic time_acc;
  logic alarm_acc;

  always_comb begin
    next_s    = s;
    time_acc  = (wr_en || rd_en) && (addr == TIME_WIN_ADDR || addr == TIME_UPPER_ADDR);
    alarm_acc = (wr_en || rd_en) && (addr == ALARM_WIN_ADDR || addr == ALARM_UPPER_ADDR);

    // Timekeeping carry chain
    if (second_tick) begin
      next_s.t_seconds_tens_digit = sec_tens_inc;
      next_s.t_seconds_ones_digit = sec_ones_inc;
      if (sec_wrap) begin
        next_s.t_minutes_tens_digit = min_tens_inc;
        next_s.t_minutes_ones_digit = min_ones_inc;
        if (min_wrap) begin
          next_s.t_hours_tens_digit = hr_tens_inc;
          next_s.t_hours_ones_digit = hr_ones_inc;
          if (hr_wrap) begin
            next_s.t_weekday_digit = (s.t_weekday_digit == WEEKDAY_DIGIT_LAST) ? 3'h0
                                   : s.t_weekday_digit + 3'h1;
          end
        end
      end
    end

    // Read data stands only in the cycle after the read strobe
    next_s.rd_data = '0;
    if (rd_en) begin
      unique case (addr)
        CTRL_ADDR: begin
          next_s.rd_data = (DATA_W'(s.wren) << WREN_BIT)
                         | (DATA_W'(s.time_ptr) << PTR_LSB);
        end
        ALARM_CFG_ADDR: begin
          next_s.rd_data = DATA_W'(s.alarm_ptr) << PTR_LSB;
        end
        TIME_WIN_ADDR, TIME_UPPER_ADDR: begin
          unique case (s.time_ptr)
            PTR_WKDY_HR: begin
              next_s.rd_data = view_wkdy_hr(s.t_weekday_digit, s.t_hours_tens_digit,
                                            s.t_hours_ones_digit);
            end
            PTR_MIN_SEC: begin
              next_s.rd_data = view_min_sec(s.t_minutes_tens_digit,
                                            s.t_minutes_ones_digit,
                                            s.t_seconds_tens_digit,
                                            s.t_seconds_ones_digit);
            end
            PTR_MONTH_DAY, PTR_YEAR: begin
              next_s.rd_data = '0;
            end
          endcase
        end
        ALARM_WIN_ADDR, ALARM_UPPER_ADDR: begin
          unique case (s.alarm_ptr)
            PTR_MONTH_DAY: begin
              next_s.rd_data = view_month_day(s.a_month_tens_digit, s.a_month_ones_digit,
                                              s.a_day_tens_digit,
                                              s.a_day_ones_digit);
            end
            PTR_WKDY_HR: begin
              next_s.rd_data = view_wkdy_hr(s.a_weekday_digit, s.a_hours_tens_digit,
                                            s.a_hours_ones_digit);
            end
            PTR_MIN_SEC: begin
              next_s.rd_data = view_min_sec(s.a_minutes_tens_digit,
                                            s.a_minutes_ones_digit,
                                            s.a_seconds_tens_digit,
                                            s.a_seconds_ones_digit);
            end
            PTR_YEAR: begin
              next_s.rd_data = '0;
            end
          endcase
        end
        default: begin
          next_s.rd_data = '0;
        end
      endcase
    end

    // Register writes; only digit, write enable and pointer fields are stored, other bits are dropped
    if (wr_en) begin
      unique case (addr)
        CTRL_ADDR: begin
          next_s.wren     = wr_data[WREN_BIT];
          next_s.time_ptr = ptr_e'(wr_data[PTR_LSB +: PTR_W]);
        end
        ALARM_CFG_ADDR: begin
          next_s.alarm_ptr = ptr_e'(wr_data[PTR_LSB +: PTR_W]);
        end
        TIME_WIN_ADDR, TIME_UPPER_ADDR: begin
          if (s.wren) begin
            unique case (s.time_ptr)
              PTR_WKDY_HR: begin
                next_s.t_weekday_digit    = wr_data[WEEKDAY_DIGIT_LSB +: 3];
                next_s.t_hours_tens_digit = wr_data[HR_TENS_LSB +: 2];
                next_s.t_hours_ones_digit = wr_data[HR_ONES_LSB +: 4];
              end
              PTR_MIN_SEC: begin
                next_s.t_minutes_tens_digit = wr_data[MIN_TENS_LSB +: 3];
                next_s.t_minutes_ones_digit = wr_data[MIN_ONES_LSB +: 4];
                next_s.t_seconds_tens_digit = wr_data[SEC_TENS_LSB +: 3];
                next_s.t_seconds_ones_digit = wr_data[SEC_ONES_LSB +: 4];
              end
              PTR_MONTH_DAY, PTR_YEAR: begin
                next_s.time_ptr = s.time_ptr;
              end
            endcase
          end
        end
        ALARM_WIN_ADDR, ALARM_UPPER_ADDR: begin
          unique case (s.alarm_ptr)
            PTR_MONTH_DAY: begin
              if (s.wren) begin
                next_s.a_month_tens_digit = wr_data[MON_TENS_LSB];
                next_s.a_month_ones_digit = wr_data[MON_ONES_LSB +: 4];
                next_s.a_day_tens_digit   = wr_data[DAY_TENS_LSB +: 2];
                next_s.a_day_ones_digit   = wr_data[DAY_ONES_LSB +: 4];
              end
            end
            PTR_WKDY_HR: begin
              if (s.wren) begin
                next_s.a_weekday_digit    = wr_data[WEEKDAY_DIGIT_LSB +: 3];
                next_s.a_hours_tens_digit = wr_data[HR_TENS_LSB +: 2];
                next_s.a_hours_ones_digit = wr_data[HR_ONES_LSB +: 4];
              end
            end
            // Alarm minutes and seconds stay writable while the lock is on
            PTR_MIN_SEC: begin
              next_s.a_minutes_tens_digit = wr_data[MIN_TENS_LSB +: 3];
              next_s.a_minutes_ones_digit = wr_data[MIN_ONES_LSB +: 4];
              next_s.a_seconds_tens_digit = wr_data[SEC_TENS_LSB +: 3];
              next_s.a_seconds_ones_digit = wr_data[SEC_ONES_LSB +: 4];
            end
            PTR_YEAR: begin
              next_s.alarm_ptr = s.alarm_ptr;
            end
          endcase
        end
        default: begin
          next_s.wren = s.wren;
        end
      endcase
    end

    // Upper window accesses walk the pointers down
    if (time_acc && addr == TIME_UPPER_ADDR) begin
      next_s.time_ptr = ptr_step(s.time_ptr);
    end
    if (alarm_acc && addr == ALARM_UPPER_ADDR) begin
      next_s.alarm_ptr = ptr_step(s.alarm_ptr);
    end
  end

  // Only control state and read data are reset; digits keep whatever they hold
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s.wren      <= 1'b0;
      s.time_ptr  <= PTR_MIN_SEC;
      s.alarm_ptr <= PTR_MIN_SEC;
      s.rd_data   <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data                  = s.rd_data;
  assign timekeeping_write_enable = s.wren;
  assign time_weekday_hours       = view_wkdy_hr(s.t_weekday_digit, s.t_hours_tens_digit,
                                                 s.t_hours_ones_digit);
  assign time_minutes_seconds     = view_min_sec(s.t_minutes_tens_digit,
                                                 s.t_minutes_ones_digit,
                                                 s.t_seconds_tens_digit,
                                                 s.t_seconds_ones_digit);
  assign alarm_month_day          = view_month_day(s.a_month_tens_digit, s.a_month_ones_digit,
                                                   s.a_day_tens_digit, s.a_day_ones_digit);
  assign alarm_weekday_hours      = view_wkdy_hr(s.a_weekday_digit, s.a_hours_tens_digit,
                                                 s.a_hours_ones_digit);
  assign alarm_minutes_seconds    = view_min_sec(s.a_minutes_tens_digit,
                                                 s.a_minutes_ones_digit,
                                                 s.a_seconds_tens_digit,
                                                 s.a_seconds_ones_digit);

endmodule : rtc_value_windows

// ===== testbench/rtc_value_windows_monitor.sv
// Assertion checker for the time and alarm value windows
`timescale 1ns/1ns
module rtc_value_windows_monitor
  import rtc_value_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic              second_tick,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              timekeeping_write_enable,
  input wire logic [DATA_W-1:0] time_weekday_hours,
  input wire logic [DATA_W-1:0] time_minutes_seconds,
  input wire logic [DATA_W-1:0] alarm_month_day,
  input wire logic [DATA_W-1:0] alarm_weekday_hours,
  input wire logic [DATA_W-1:0] alarm_minutes_seconds
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic time_wr;
  logic alarm_wr;
  assign time_wr  = wr_en && (addr == TIME_WIN_ADDR || addr == TIME_UPPER_ADDR);
  assign alarm_wr = wr_en && (addr == ALARM_WIN_ADDR || addr == ALARM_UPPER_ADDR);
  sequence s_locked_time_wr;
    time_wr && !timekeeping_write_enable && !second_tick;
  endsequence
  sequence s_quiet;
    !time_wr && !second_tick;
  endsequence
  sequence s_tick_only;
    second_tick && !time_wr;
  endsequence
  chk_time_lock: assert property (s_locked_time_wr |=>
    $stable(time_weekday_hours) && $stable(time_minutes_seconds))
    else $error("time write not locked");
  chk_alarm_lock: assert property (alarm_wr && !timekeeping_write_enable |=>
    $stable(alarm_month_day) && $stable(alarm_weekday_hours)) else $error("alarm write not locked");
  chk_unused_zero: assert property (
    (time_weekday_hours & 16'hF8C0) == 16'h0000 && (time_minutes_seconds & 16'h8080) == 16'h0000
    && (alarm_month_day & 16'hE0C0) == 16'h0000 && (alarm_weekday_hours & 16'hF8C0) == 16'h0000
    && (alarm_minutes_seconds & 16'h8080) == 16'h0000) else $error("unused window bit set");
  chk_unmapped_zero: assert property (rd_en && addr > ALARM_UPPER_ADDR |=> rd_data == 16'h0000)
    else $error("unmapped read not zero");
  chk_rd_only_after: assert property (rd_data != 16'h0000 |-> $past(rd_en))
    else $error("read data outside read slot");
  chk_wren_copy: assert property (wr_en && addr == CTRL_ADDR |=>
    timekeeping_write_enable == $past(wr_data[WREN_BIT])) else $error("write enable not taken");
  chk_wren_steady: assert property (!(wr_en && addr == CTRL_ADDR) |=>
    $stable(timekeeping_write_enable)) else $error("write enable moved by itself");
  chk_ctrl_read: assert property (rd_en && addr == CTRL_ADDR |=>
    rd_data[WREN_BIT] == timekeeping_write_enable) else $error("write enable read wrong");
  chk_time_hold: assert property (s_quiet |=>
    $stable(time_minutes_seconds) && $stable(time_weekday_hours)) else $error("time moved idle");
  chk_sec_step: assert property (s_tick_only ##0 time_minutes_seconds[3:0] < ONES_LAST |=>
    time_minutes_seconds[3:0] == $past(time_minutes_seconds[3:0]) + 4'h1
    && $stable(time_minutes_seconds[15:4])) else $error("seconds step wrong");
  chk_min_wrap: assert property (s_tick_only ##0 time_minutes_seconds == 16'h5959 |=>
    time_minutes_seconds == 16'h0000) else $error("minute wrap wrong");
endmodule : rtc_value_windows_monitor

bind rtc_value_windows rtc_value_windows_monitor u_mon (
  .ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .second_tick(second_tick), .rd_data(rd_data),
  .timekeeping_write_enable(timekeeping_write_enable),
  .time_weekday_hours(time_weekday_hours), .time_minutes_seconds(time_minutes_seconds),
  .alarm_month_day(alarm_month_day), .alarm_weekday_hours(alarm_weekday_hours),
  .alarm_minutes_seconds(alarm_minutes_seconds)
);

// ===== testbench/rtc_value_windows_test.sv
// Self-checking bench for the time and alarm value windows
`timescale 1ns/1ns
module rtc_value_windows_test;
  import rtc_value_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic              second_tick = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic              twe;
  logic [DATA_W-1:0] twh;
  logic [DATA_W-1:0] tms;
  logic [DATA_W-1:0] amd;
  logic [DATA_W-1:0] awho;
  logic [DATA_W-1:0] amso;
  logic [31:0]       seed = 32'h0000EC7F;
  logic [15:0]       wh, ms, md, awh, ams, got;
  logic [31:0]       t;
  int                n_fail = 0;
  int                checked = 0;

  rtc_value_windows DUT (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .second_tick(second_tick), .rd_data(rd_data),
    .timekeeping_write_enable(twe), .time_weekday_hours(twh), .time_minutes_seconds(tms),
    .alarm_month_day(amd), .alarm_weekday_hours(awho), .alarm_minutes_seconds(amso)
  );

  always #20 ref_clk = ~ref_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [15:0] rand_wh();
    logic [1:0] ht;
    ht = 2'(rnd() % 3);
    return {5'h00, 3'(rnd() % 7), 2'h0, ht, 4'(rnd() % ((ht == 2'h2) ? 4 : 10))};
  endfunction : rand_wh

  function automatic logic [15:0] rand_ms();
    return {1'b0, 3'(rnd() % 6), 4'(rnd() % 10), 1'b0, 3'(rnd() % 6), 4'(rnd() % 10)};
  endfunction : rand_ms

  function automatic logic [15:0] rand_md();
    return {3'h0, 1'(rnd() % 2), 4'(rnd() % 10), 2'h0, 2'(rnd() % 4), 4'(rnd() % 10)};
  endfunction : rand_md

  // One second later for {weekday_hours, minutes_seconds}
  function automatic logic [31:0] next_time(input logic [31:0] t);
    logic [31:0] n;
    logic        c;
    n = t;
    n[3:0] = (t[3:0] == 4'h9) ? 4'h0 : t[3:0] + 4'h1;
    c = t[3:0] == 4'h9;
    n[6:4] = c ? ((t[6:4] == 3'h5) ? 3'h0 : t[6:4] + 3'h1) : t[6:4];
    c = c && t[6:4] == 3'h5;
    n[11:8] = c ? ((t[11:8] == 4'h9) ? 4'h0 : t[11:8] + 4'h1) : t[11:8];
    c = c && t[11:8] == 4'h9;
    n[14:12] = c ? ((t[14:12] == 3'h5) ? 3'h0 : t[14:12] + 3'h1) : t[14:12];
    c = c && t[14:12] == 3'h5;
    if (c && t[21:16] == 6'h23) begin
      n[21:16] = 6'h00;
      n[26:24] = (t[26:24] == 3'h6) ? 3'h0 : t[26:24] + 3'h1;
    end else if (c) begin
      n[21:16] = (t[19:16] == 4'h9) ? {t[21:20] + 2'h1, 4'h0} : {t[21:20], t[19:16] + 4'h1};
    end
    return n;
  endfunction : next_time

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  task automatic tick();
    @(posedge ref_clk);
    second_tick <= 1'b1;
    @(posedge ref_clk);
    second_tick <= 1'b0;
    #1;
  endtask : tick

  task automatic summarize();
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    #2000000;
    n_fail++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rd(CTRL_ADDR, got);
    chk("ctrl_reset", got, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, got);
    chk("unmapped", got, 16'h0000);
    for (int i = 0; i < 20; i++) begin
      wh = rand_wh();
      ms = rand_ms();
      md = rand_md();
      awh = rand_wh();
      ams = rand_ms();
      // Unused bits are written as ones and must read back clear
      wr(CTRL_ADDR, 16'h2100);
      chk("wren_on", {15'h0000, twe}, 16'h0001);
      wr(TIME_UPPER_ADDR, wh | 16'hF8C0);
      wr(TIME_UPPER_ADDR, ms | 16'h8080);
      wr(ALARM_CFG_ADDR, 16'h0200);
      wr(ALARM_UPPER_ADDR, md | 16'hE0C0);
      wr(ALARM_UPPER_ADDR, awh | 16'hF8C0);
      wr(ALARM_UPPER_ADDR, ams | 16'h8080);
      wr(CTRL_ADDR, 16'h2100);
      rd(TIME_WIN_ADDR, got);
      chk("time_win", got, wh);
      rd(TIME_UPPER_ADDR, got);
      chk("time_up1", got, wh);
      rd(TIME_UPPER_ADDR, got);
      chk("time_up0", got, ms);
      rd(TIME_UPPER_ADDR, got);
      chk("time_stop", got, ms);
      wr(ALARM_CFG_ADDR, 16'h0200);
      rd(ALARM_UPPER_ADDR, got);
      chk("alarm_md", got, md);
      rd(ALARM_UPPER_ADDR, got);
      chk("alarm_wh", got, awh);
      rd(ALARM_UPPER_ADDR, got);
      chk("alarm_ms", got, ams);
      rd(ALARM_UPPER_ADDR, got);
      chk("alarm_stop", got, ams);
      // Locked writes are dropped except alarm minutes/seconds; upper window writes still step the pointers
      wr(CTRL_ADDR, 16'h0100);
      chk("wren_off", {15'h0000, twe}, 16'h0000);
      wr(TIME_UPPER_ADDR, ~wh);
      wr(TIME_WIN_ADDR, ~ms);
      chk("twh_locked", twh, wh);
      chk("tms_locked", tms, ms);
      ams = rand_ms();
      wr(ALARM_CFG_ADDR, 16'h0200);
      wr(ALARM_UPPER_ADDR, ~md);
      wr(ALARM_UPPER_ADDR, ~awh);
      wr(ALARM_UPPER_ADDR, ams);
      chk("amd_locked", amd, md);
      chk("awh_locked", awho, awh);
      chk("ams_open", amso, ams);
      rd(CTRL_ADDR, got);
      chk("ctrl_ptr", got, 16'h0000);
      rd(ALARM_CFG_ADDR, got);
      chk("alarm_ptr", got, 16'h0000);
      t = next_time({wh, ms});
      tick();
      chk("tick_wh", twh, t[31:16]);
      chk("tick_ms", tms, t[15:0]);
    end
    wr(CTRL_ADDR, 16'h2100);
    wr(TIME_UPPER_ADDR, 16'h0623);
    wr(TIME_UPPER_ADDR, 16'h5959);
    tick();
    chk("wrap_wh", twh, 16'h0000);
    chk("wrap_ms", tms, 16'h0000);
    wr(CTRL_ADDR, 16'h2300);
    rd(TIME_WIN_ADDR, got);
    chk("time_ptr3", got, 16'h0000);
    wr(TIME_WIN_ADDR, 16'hFFFF);
    chk("ptr3_wr_wh", twh, 16'h0000);
    chk("ptr3_wr_ms", tms, 16'h0000);
    wr(ALARM_CFG_ADDR, 16'h0300);
    rd(ALARM_WIN_ADDR, got);
    chk("alarm_ptr3", got, 16'h0000);
    // Reset in mid-run clears the lock and both pointers
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(CTRL_ADDR, got);
    chk("ctrl_rerst", got, 16'h0000);
    chk("wren_rerst", {15'h0000, twe}, 16'h0000);
    rd(ALARM_CFG_ADDR, got);
    chk("alarm_rerst", got, 16'h0000);
    summarize();
  end
endmodule : rtc_value_windows_test
